// [hdl/hprw_pkg.sv]
package hprw_pkg;

	// Register byte offsets on the Wishbone slave.
	localparam logic [7:0] OFS_ATX_CFG = 8'h00;
	localparam logic [7:0] OFS_WDOG    = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_ANSWER  = 8'h0c;
	localparam logic [7:0] OFS_BOOT    = 8'h10;

	// Field positions inside the configuration write word.
	localparam int LEN_LSB     = 8;
	localparam int LEN_PRESENT = 16;

	// Function mask bits.
	localparam logic [7:0] FN_RST_INV   = 8'h02;
	localparam logic [7:0] FN_PWR_INV   = 8'h04;
	localparam logic [7:0] FN_WD_ACTIVE = 8'h08;
	localparam logic [7:0] FN_BLANK     = 8'h10;
	localparam logic [7:0] FN_KP_RST    = 8'h20;
	localparam logic [7:0] FN_KP_PON    = 8'h40;
	localparam logic [7:0] FN_KP_POFF   = 8'h80;

	// Command codes and the answer flag.
	localparam logic [7:0] CMD_STORE = 8'h04;
	localparam logic [7:0] CMD_ATX   = 8'h1c;
	localparam logic [7:0] CMD_WDOG  = 8'h1d;
	localparam logic [7:0] ANS_FLAG  = 8'h40;

	// Values after reset (factory boot state).
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] LEN_RST  = 8'h00;

	// Time base: all long times count in 1/32 second ticks.
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_NS       = 31_250_000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int TICKS_PER_S   = 32;
	localparam int HOLD_LONG_MS  = 4000;
	localparam int HOLD_SHORT_MS = 250;
	localparam int RST_PULSE_MS  = 1000;
	localparam int EXTEND_MS     = 5000;
	localparam logic [8:0] HOLD_LONG_T  = 9'(HOLD_LONG_MS * TICKS_PER_S / 1000);
	localparam logic [8:0] HOLD_SHORT_T = 9'(HOLD_SHORT_MS * TICKS_PER_S / 1000);
	localparam logic [8:0] RST_PULSE_T  = 9'(RST_PULSE_MS * TICKS_PER_S / 1000);
	localparam logic [8:0] EXTEND_T     = 9'(EXTEND_MS * TICKS_PER_S / 1000);
	localparam logic [4:0] SEC_LAST_T   = 5'(TICKS_PER_S - 1);

	// One open-drain style line: drive value and its enable.
	typedef struct packed {
		logic drive_val;
		logic drive_en;
	} hprw_line_type;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_RST    = 3'b001,
		ST_PWR    = 3'b010,
		ST_EXTEND = 3'b011,
		ST_REINIT = 3'b100,
		ST_WAIT   = 3'b101
	} hprw_state_type;

endpackage : hprw_pkg

// [hdl/hprw_key_hold.sv]
`timescale 1ns/1ps
// Counts ticks of uninterrupted key hold; saturates at the top.
module hprw_key_hold (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Synchronised key level and time base.
	input  wire logic       key_held,
	input  wire logic       tick,
	// Hold time in ticks.
	output logic [8:0]      held_ticks
);
	import hprw_pkg::*;

	logic [8:0] held_reg;  // Ticks seen while key stayed down.
	logic [8:0] held_next; // Next hold count.

	// Release clears the count so only an unbroken hold counts.
	assign held_next = !key_held ? 9'h000 :
		(tick && held_reg != 9'h1ff) ? held_reg + 9'h001 : held_reg;
	assign held_ticks = held_reg;

	// Hold counter.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			held_reg <= 9'h000;
		end else begin
			held_reg <= held_next;
		end
	end

	// A released key reads zero hold time one edge later.
	release_clears_a: assert property (@(posedge sys_clk) disable iff (rst)
		!key_held |=> held_reg == 9'h000)
		else $error("hold count survived a key release");
endmodule : hprw_key_hold

// [hdl/hprw_sequencer.sv]
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Host power and reset switch sequencer with watchdog.
module hprw_sequencer #(
	parameter int TICK_CYC_P = hprw_pkg::TICK_CYC // Clocks per 1/32 s.
) (
	// Clock and reset.
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Wishbone classic slave.
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	// Pins from outside the clock domain.
	input  wire logic                  host_sense_i,
	input  wire logic                  key_confirm_i,
	input  wire logic                  key_cancel_i,
	// Host switch lines.
	output hprw_pkg::hprw_line_type    reset_line,
	output hprw_pkg::hprw_line_type    power_line,
	// Display side.
	output logic                       display_blank,
	output logic [1:0]                 message_code,
	output logic                       self_reinit
);
	import hprw_pkg::*;

	// Pin synchronisers: index 0 sense, 1 confirm, 2 cancel.
	logic [2:0] pin_raw;
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [8:0] held [2];
	logic       tick; // Time base; declared here for the hold timers.
	assign pin_raw = {key_cancel_i, key_confirm_i, host_sense_i};

	// Each pin passes two flops; hold timers sit on the keys only.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
			if (gi > 0) begin : g_hold
				hprw_key_hold u_hold (
					.sys_clk    (sys_clk),
					.rst        (rst),
					.key_held   (sync2_reg[gi]),
					.tick       (tick),
					.held_ticks (held[gi-1])
				);
			end
		end
	endgenerate

	wire sense   = sync2_reg[0];
	logic sense_d_reg; // Sense one cycle ago, for rise detect.
	wire sense_rise = sense && !sense_d_reg;

	// Tick generator: one pulse each 1/32 second.
	logic [22:0] tick_cnt_reg;
	assign tick = (tick_cnt_reg == 23'(TICK_CYC_P - 1));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_reg <= 23'h000000;
			sense_d_reg  <= 1'b0;
		end else begin
			tick_cnt_reg <= tick ? 23'h000000 : tick_cnt_reg + 23'h000001;
			sense_d_reg  <= sense;
		end
	end

	// Live and boot configuration.
	logic [7:0] mask_reg, mask_next;     // Enabled functions.
	logic [7:0] len_reg, len_next;       // Pulse length, 0 = default.
	logic [7:0] boot_mask_reg;           // Saved mask.
	logic [7:0] boot_len_reg;            // Saved length.
	hprw_state_type state_reg, state_next;

	// Bus decode. A write lands on the edge that raises ack.
	wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_go     = bus_req && wb_we_i && wb_sel_i[0];
	wire locked    = (state_reg == ST_REINIT) || (state_reg == ST_WAIT);
	// Commands are swallowed in ST_REINIT and ST_WAIT, until the keys come up.
	wire wr_cfg    = wr_go && !locked && wb_adr_i == OFS_ATX_CFG;
	wire wr_wdog   = wr_go && !locked && wb_adr_i == OFS_WDOG;
	wire wr_boot   = wr_go && !locked && wb_adr_i == OFS_BOOT;
	wire rd_answer = bus_req && !wb_we_i && wb_adr_i == OFS_ANSWER;
	wire reinit    = (state_reg == ST_REINIT);

	// Mask is byte 0, optional length byte 1 when flagged.
	assign mask_next = reinit ? boot_mask_reg :
		wr_cfg ? wb_dat_i[7:0] : mask_reg;
	assign len_next  = reinit ? boot_len_reg :
		!wr_cfg ? len_reg :
		wb_dat_i[LEN_PRESENT] ? wb_dat_i[LEN_LSB +: 8] : 8'h00;

	// Configuration registers; reinit reloads the boot copy.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask_reg      <= MASK_RST;
			len_reg       <= LEN_RST;
			boot_mask_reg <= MASK_RST;
			boot_len_reg  <= LEN_RST;
		end else begin
			mask_reg <= mask_next;
			len_reg  <= len_next;
			if (wr_boot) begin
				boot_mask_reg <= mask_reg;
				boot_len_reg  <= len_reg;
			end
		end
	end

	// Watchdog: seconds left, sub-second ticks, armed flag.
	logic [7:0] wd_cnt_reg;
	logic [4:0] wd_sub_reg;
	logic       wd_on_reg;
	wire wd_second = wd_on_reg && tick && wd_sub_reg == SEC_LAST_T;
	wire wd_expire = wd_second && wd_cnt_reg == 8'h01;

	// Zero disarms, nonzero re-arms; expiry and reinit disarm.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wd_on_reg  <= 1'b0;
			wd_cnt_reg <= 8'h00;
			wd_sub_reg <= 5'h00;
		end else if (wr_wdog) begin
			wd_on_reg  <= wb_dat_i[7:0] != 8'h00;
			wd_cnt_reg <= wb_dat_i[7:0];
			wd_sub_reg <= 5'h00;
		end else if (wd_expire || reinit) begin
			wd_on_reg  <= 1'b0;
			wd_cnt_reg <= 8'h00;
		end else if (wd_on_reg && tick) begin
			wd_sub_reg <= wd_sub_reg + 5'h01;
			if (wd_second) begin
				wd_cnt_reg <= wd_cnt_reg - 8'h01;
			end
		end
	end

	// Keypad trigger conditions.
	wire kp_rst  = mask_reg[5] && sense && held[0] >= HOLD_LONG_T;
	wire kp_pon  = mask_reg[6] && !sense && held[0] >= HOLD_SHORT_T;
	wire kp_poff = mask_reg[7] && sense && held[1] >= HOLD_LONG_T;
	// Blank mode reboots the unit when the host comes up.
	wire blank_on  = (mask_reg & FN_BLANK) != 8'h00 && !sense;
	wire boot_rise = (mask_reg & FN_BLANK) != 8'h00 && sense_rise;

	// Pulse timer in ticks and the power-off direction flag.
	logic [8:0] pulse_reg, pulse_next;
	logic       poff_reg, poff_next;
	wire [8:0] pwr_len = (len_reg == 8'h00) ? 9'(TICKS_PER_S) :
		{1'b0, len_reg};
	wire pulse_done = tick && pulse_reg == 9'h001;

	// Sequencer next state.
	always_comb begin
		state_next = state_reg;
		pulse_next = tick ? pulse_reg - 9'h001 : pulse_reg;
		poff_next  = poff_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (kp_rst || wd_expire) begin
					state_next = ST_RST;
					pulse_next = RST_PULSE_T;
				end else if (kp_pon) begin
					state_next = ST_PWR;
					pulse_next = pwr_len;
					poff_next  = 1'b0;
				end else if (kp_poff) begin
					state_next = ST_PWR;
					pulse_next = pwr_len;
					poff_next  = 1'b1;
				end else if (boot_rise) begin
					state_next = ST_REINIT;
				end
			end
			ST_RST: begin
				if (pulse_done) begin
					state_next = ST_REINIT;
				end
			end
			ST_PWR: begin
				if (pulse_done && poff_reg && sync2_reg[2]) begin
					state_next = ST_EXTEND;
					pulse_next = EXTEND_T;
				end else if (pulse_done) begin
					state_next = poff_reg ? ST_WAIT : ST_REINIT;
				end
			end
			ST_EXTEND: begin
				// Key release or the 5 s cap ends the drive.
				if (!sync2_reg[2] || pulse_done) begin
					state_next = ST_WAIT;
				end
			end
			ST_REINIT: begin
				state_next = ST_WAIT;
			end
			ST_WAIT: begin
				// Keys must come up so one hold fires only once.
				if (!sync2_reg[1] && !sync2_reg[2]) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	// Line drive follows the next state so the pins are flops.
	wire rst_drive = (state_next == ST_RST);
	wire pwr_drive = (state_next == ST_PWR) || (state_next == ST_EXTEND);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			pulse_reg     <= 9'h000;
			poff_reg      <= 1'b0;
			reset_line    <= '0;
			power_line    <= '0;
			display_blank <= 1'b0;
			message_code  <= 2'h0;
			self_reinit   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			pulse_reg  <= pulse_next;
			poff_reg   <= poff_next;
			// Low by default, high when the invert bit is set.
			reset_line <= '{drive_val: mask_reg[1], drive_en: rst_drive};
			power_line <= '{drive_val: mask_reg[2], drive_en: pwr_drive};
			display_blank <= blank_on;
			// Message: 1 reset, 2 power on, 3 power off.
			message_code <= rst_drive ? 2'h1 :
				!pwr_drive ? 2'h0 : poff_next ? 2'h3 : 2'h2;
			self_reinit <= (state_next == ST_REINIT);
		end
	end

	// Answer register: code of the last accepted command.
	logic [7:0] ans_type_reg;
	logic       ans_valid_reg;
	wire        cmd_taken = wr_cfg || wr_wdog || wr_boot;
	wire [7:0]  cmd_code  = wr_cfg ? CMD_ATX : wr_wdog ? CMD_WDOG : CMD_STORE;

	// A new answer beats the read that would clear the flag.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ans_type_reg  <= 8'h00;
			ans_valid_reg <= 1'b0;
		end else if (cmd_taken) begin
			ans_type_reg  <= cmd_code | ANS_FLAG;
			ans_valid_reg <= 1'b1;
		end else if (rd_answer) begin
			ans_valid_reg <= 1'b0;
		end
	end

	// Read mux; unmapped offsets read zero and still acknowledge.
	wire [7:0] mask_view = wd_on_reg ? (mask_reg | FN_WD_ACTIVE) :
		mask_reg;
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h00000000;
		unique case (wb_adr_i)
			OFS_ATX_CFG: rd_data = {16'h0000, len_reg, mask_reg};
			OFS_WDOG:    rd_data = {24'h000000, wd_cnt_reg};
			OFS_STATUS:  rd_data = {13'h0000, locked, sense,
				wd_on_reg, wd_cnt_reg, mask_view};
			OFS_ANSWER:  rd_data = {23'h000000, ans_valid_reg,
				ans_type_reg};
			default:     rd_data = 32'h00000000;
		endcase
	end

	// Classic Wishbone: ack one cycle after the strobe, then drop.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h00000000;
		end
	end

	// Lines float whenever the sequencer is idle.
	idle_lines_float_a: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_IDLE |-> !reset_line.drive_en && !power_line.drive_en)
		else $error("line driven while idle");
	// Drive level matches the invert bit.
	reset_polarity_a: assert property (@(posedge sys_clk) disable iff (rst)
		reset_line.drive_en && $stable(mask_reg) |->
		reset_line.drive_val == mask_reg[1])
		else $error("reset line polarity wrong");
	// A keypad reset hold starts a reset pulse next cycle.
	keypad_reset_go_a: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_IDLE && kp_rst |=> reset_line.drive_en)
		else $error("reset pulse missed after long hold");
	// Writes during the lockout change nothing.
	locked_ignores_a: assert property (@(posedge sys_clk) disable iff (rst)
		locked && !reinit && wr_go |=>
		$stable(mask_reg) && $stable(len_reg))
		else $error("command taken during lockout");
	// Power-on keystroke drives the power line.
	power_on_go_a: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_IDLE && !kp_rst && !wd_expire && kp_pon
		|=> power_line.drive_en && message_code == 2'h2)
		else $error("power pulse missed for power on");
	// Extension lasts no more than the cap once started.
	extend_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_EXTEND |-> pulse_reg <= EXTEND_T)
		else $error("power-off extension too long");
	// Blanking tracks the enable bit and sense.
	blank_track_a: assert property (@(posedge sys_clk) disable iff (rst)
		##1 display_blank == $past(blank_on))
		else $error("display blank out of step");
	// Answer code is the command ORed with the flag.
	answer_code_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_wdog |=> ans_valid_reg && ans_type_reg == 8'h5d)
		else $error("bad answer code");
	// Expiry disarms and starts the host reset.
	expiry_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
		wd_expire && !wr_wdog && state_reg == ST_IDLE
		|=> !wd_on_reg && reset_line.drive_en)
		else $error("watchdog expiry mishandled");
	// Zero write disarms, nonzero arms.
	wd_arm_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_wdog |=> wd_on_reg == ($past(wb_dat_i[7:0]) != 8'h00))
		else $error("watchdog arm state wrong");
	// Ack is a single-cycle answer to each strobe.
	bus_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
		bus_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("wishbone ack timing wrong");

	reset_pulse_c: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_RST ##1 state_reg == ST_REINIT);
	extend_c: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_EXTEND);
	wd_expire_c: cover property (@(posedge sys_clk) disable iff (rst)
		wd_expire);
	boot_rise_c: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_IDLE && boot_rise);
endmodule : hprw_sequencer

// [dv/hprw_host_model.sv]
`timescale 1ns/1ps
// Host board model: switch inputs with pull-ups, power toggled per press.
module hprw_host_model (
	// Clock and reset.
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	// Switch lines from the unit.
	input  wire hprw_pkg::hprw_line_type reset_line,
	input  wire hprw_pkg::hprw_line_type power_line,
	// Host power sense and pulse records, index 0 reset, 1 power.
	output logic                         host_sense,
	output int                           pulse_cnt [2],
	output int                           pulse_len [2],
	output logic                         pulse_lvl [2]
);
	import hprw_pkg::*;

	logic [1:0] en;     // Drive enables of both lines.
	logic [1:0] lvl;    // Resolved wire levels.
	logic [1:0] was_en; // Enables one cycle ago.

	// A floating line reads the board pull-up, so it never shows a
	// stale driven value; the pins are left in their default drive.
	assign en = {power_line.drive_en, reset_line.drive_en};
	assign lvl[0] = reset_line.drive_en ? reset_line.drive_val : 1'b1;
	assign lvl[1] = power_line.drive_en ? power_line.drive_val : 1'b1;

	// Measure each pulse; the host flips its power when a press ends.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			was_en     <= 2'h0;
			host_sense <= 1'b0;
			pulse_cnt  <= '{0, 0};
			pulse_len  <= '{0, 0};
			pulse_lvl  <= '{1'b1, 1'b1};
		end else begin
			was_en <= en;
			for (int i = 0; i < 2; i++) begin
				// Count cycles while driven and keep the driven level.
				if (en[i]) begin
					pulse_len[i] <= was_en[i] ? pulse_len[i] + 1 : 1;
					pulse_lvl[i] <= lvl[i];
				end
				// A pulse is counted once the line floats again.
				if (!en[i] && was_en[i]) begin
					pulse_cnt[i] <= pulse_cnt[i] + 1;
				end
			end
			// Sense is pulled up when on and pulled low when off.
			if (!en[1] && was_en[1]) begin
				host_sense <= !host_sense;
			end
		end
	end
endmodule : hprw_host_model

// [dv/testbench.sv]
`timescale 1ns/1ps
// Bench for the host switch sequencer over its register bus.
module testbench;
	import hprw_pkg::*;

	localparam int T = 4; // Clocks per tick, short to keep the run brief.
	localparam logic [31:0] CFG = 32'h0001_02f4; // Length 2, all functions except reset invert and watchdog active.

	logic          sys_clk;
	logic          rst;
	logic          wb_cyc;
	logic          wb_stb;
	logic          wb_we;
	logic [7:0]    wb_adr;
	logic [31:0]   wb_wdat;
	logic [31:0]   wb_dat_o;
	logic          wb_ack_o;
	logic [31:0]   rdat;          // Data of the last read.
	logic          key_confirm;
	logic          key_cancel;
	logic          host_sense;
	hprw_line_type reset_line;
	hprw_line_type power_line;
	logic          display_blank;
	logic          self_reinit;
	logic [1:0]    message_code;
	logic [1:0]    msg_seen;      // Message shown during the last pulse.
	int            pulse_cnt [2];
	int            pulse_len [2];
	logic          pulse_lvl [2];
	int            fail_count;
	int            total_checks;
	int            reinit_cnt;    // Count of unit restarts seen.

	hprw_sequencer #(.TICK_CYC_P(T)) DUT (
		.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.host_sense_i(host_sense), .key_confirm_i(key_confirm),
		.key_cancel_i(key_cancel), .reset_line(reset_line),
		.power_line(power_line), .display_blank(display_blank),
		.message_code(message_code), .self_reinit(self_reinit));

	hprw_host_model host (
		.sys_clk(sys_clk), .rst(rst), .reset_line(reset_line),
		.power_line(power_line), .host_sense(host_sense),
		.pulse_cnt(pulse_cnt), .pulse_len(pulse_len), .pulse_lvl(pulse_lvl));

	// Clock generator.
	always #2 sys_clk = ~sys_clk;

	// The restart strobe stands one cycle, so it is looked at every edge.
	always @(posedge sys_clk) begin
		if (self_reinit === 1'b1) begin
			reinit_cnt++;
		end
		// Keep the message that stood while a line was driven.
		if (reset_line.drive_en || power_line.drive_en) begin
			msg_seen <= message_code;
		end
	end

	// Print counts and the verdict, then stop.
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	// Compare a value of the design against its expectation.
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Compare a measured pulse length against a window in clocks.
	task chk_rng(input string what, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng

	// One classic Wishbone cycle; the request holds until ack is sampled.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_wdat <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			$display("MISMATCH wb_ack expected 1 seen none");
			conclude();
		end
	endtask : wb

	// Read a register and compare it.
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask : rd_chk

	// Wait, bounded, for the next completed pulse on line i.
	task wait_cnt(input int i, input int lim);
		int base;
		int n;
		base = pulse_cnt[i];
		n = 0;
		while (pulse_cnt[i] == base && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			$display("MISMATCH pulse_wait expected pulse seen none");
			conclude();
		end
	endtask : wait_cnt

	// Set both keys just after an edge.
	task keys(input logic c, input logic x);
		@(posedge sys_clk);
		key_confirm <= c;
		key_cancel  <= x;
	endtask : keys

	// Main sequence: boot, keypad power and reset, watchdog, power-off.
	initial begin
		{sys_clk, wb_cyc, wb_stb, wb_we, key_confirm, key_cancel} = 6'h0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0;
		{fail_count, total_checks} = {32'h0, 32'h0};
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		chk("lines_idle", 2'b00, {reset_line.drive_en, power_line.drive_en});
		rd_chk(OFS_STATUS, 32'h0, "status_boot");
		rd_chk(8'h14, 32'h0, "unmapped");
		rd_chk(OFS_ANSWER, 32'h0, "answer_none");
		wb(1'b1, OFS_ATX_CFG, CFG);
		rd_chk(OFS_ANSWER, {23'h0, 1'b1, CMD_ATX | ANS_FLAG}, "ans_cfg");
		rd_chk(OFS_ATX_CFG, {16'h0, 8'h02, 8'hf4}, "cfg_read");
		wb(1'b1, OFS_BOOT, 32'h0);
		rd_chk(OFS_ANSWER, {23'h0, 1'b1, CMD_STORE | ANS_FLAG}, "ans_st");
		repeat (4) @(posedge sys_clk);
		chk("blank_host_off", 1'b1, display_blank);
		// Short confirm press while the host is off.
		keys(1'b1, 1'b0);
		wait_cnt(1, 20 * T + 40);
		keys(1'b0, 1'b0);
		chk_rng("pwr_on_len", T, 3 * T, pulse_len[1]);
		chk("pwr_on_lvl", 1'b1, pulse_lvl[1]);
		chk("pwr_on_msg", 2'h2, msg_seen);
		repeat (20) @(posedge sys_clk);
		chk("pwr_on_reinit", 1'b1, reinit_cnt != 0);
		chk("blank_host_on", 1'b0, display_blank);
		rd_chk(OFS_ATX_CFG, {16'h0, 8'h02, 8'hf4}, "cfg_restored");
		// An interrupted hold must start counting again.
		keys(1'b1, 1'b0);
		repeat (100 * T) @(posedge sys_clk);
		keys(1'b0, 1'b0);
		repeat (10) @(posedge sys_clk);
		keys(1'b1, 1'b0);
		repeat (100 * T) @(posedge sys_clk);
		chk("hold_restart", 0, pulse_cnt[0]);
		wait_cnt(0, 80 * T);
		chk_rng("rst_len", 31 * T, 33 * T, pulse_len[0]);
		chk("rst_lvl", 1'b0, pulse_lvl[0]);
		chk("rst_msg", 2'h1, msg_seen);
		chk("rst_reinit", 2, reinit_cnt);
		// Key still held: commands are dropped until it is released.
		wb(1'b1, OFS_ATX_CFG, 32'h0);
		rd_chk(OFS_ATX_CFG, {16'h0, 8'h02, 8'hf4}, "cfg_locked");
		keys(1'b0, 1'b0);
		repeat (10) @(posedge sys_clk);
		wb(1'b1, OFS_WDOG, 32'h1);
		rd_chk(OFS_STATUS, 32'h0003_01fc, "status_armed");
		wb(1'b1, OFS_WDOG, 32'h0);
		rd_chk(OFS_STATUS, 32'h0002_00f4, "status_off");
		// A refresh before expiry keeps the host running.
		wb(1'b1, OFS_WDOG, 32'h2);
		repeat (230) @(posedge sys_clk);
		wb(1'b1, OFS_WDOG, 32'h2);
		repeat (230) @(posedge sys_clk);
		chk("wd_refresh", 1, pulse_cnt[0]);
		wait_cnt(0, 600);
		chk_rng("wd_rst_len", 31 * T, 33 * T, pulse_len[0]);
		repeat (20) @(posedge sys_clk);
		rd_chk(OFS_STATUS, 32'h0002_00f4, "wd_disarmed");
		repeat (600) @(posedge sys_clk);
		chk("wd_no_repeat", 2, pulse_cnt[0]);
		// Cancel held throughout: pulse runs on up to the extension.
		keys(1'b0, 1'b1);
		wait_cnt(1, 400 * T);
		keys(1'b0, 1'b0);
		chk_rng("pwr_off_len", 160 * T, 163 * T, pulse_len[1]);
		chk("pwr_off_msg", 2'h3, msg_seen);
		repeat (20) @(posedge sys_clk);
		chk("blank_after_off", 1'b1, display_blank);
		conclude();
	end
endmodule : testbench
